// ### aperture_cfg_pkg.sv
package aperture_cfg_pkg;

  // configuration byte offsets; the low two bits pick the byte lane in a dword
  localparam logic [7:0]  APERTURE_BASE_OFS  = 8'h10;
  localparam logic [7:0]  SUBSYS_VENDOR_OFS  = 8'h2C;
  localparam logic [7:0]  SUBSYS_IDENT_OFS   = 8'h2E;
  localparam logic [7:0]  CAP_LIST_PTR_OFS   = 8'h34;

  // reset values
  localparam logic [31:0] BASE_RESET_AGP     = 32'h00000008;
  localparam logic [31:0] BASE_RESET_GRAPH   = 32'h00000000;
  localparam logic [15:0] IDENT_RESET        = 16'h0000;
  localparam logic [7:0]  CAP_LIST_PTR_VALUE = 8'h88;

  // field positions in the aperture base register
  localparam int          BASE_HI_MSB        = 31;
  localparam int          BASE_HI_LSB        = 26;
  localparam int          BASE_SIZE_BIT      = 25;
  localparam int          BASE_ZERO_MSB      = 24;
  localparam int          BASE_ZERO_LSB      = 4;
  localparam int          BASE_HI_WIDTH      = BASE_HI_MSB - BASE_HI_LSB + 1;
  localparam int          BASE_ZERO_WIDTH    = BASE_ZERO_MSB - BASE_ZERO_LSB + 1;

  // bits of the outside size and control registers
  localparam int          SIZE_SELECT_BIT    = 3;
  localparam int          APERTURE_EN_BIT    = 1;

  // byte enable lane that carries bits 31:24
  localparam int          BASE_HI_LANE       = 3;
  localparam int          IDENT_WIDTH        = 16;

endpackage

// ### write_once_reg.sv
`timescale 1ns/1ps

// 16-bit register that takes its first write and then holds until reset
module write_once_reg (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  wr_be,
  input  wire logic [15:0] wdata,
  output logic      [15:0] value,
  output logic             locked
);

  logic [15:0] value_q;
  logic [15:0] value_d;
  logic        locked_q;
  logic        take_write;

  // the first write of any byte locks both bytes, so a half-written id cannot be patched later
  assign take_write = (|wr_be) && !locked_q; // RL13
  assign value_d[7:0]  = (take_write && wr_be[0]) ? wdata[7:0]  : value_q[7:0];
  assign value_d[15:8] = (take_write && wr_be[1]) ? wdata[15:8] : value_q[15:8];

  // only reset clears value and lock
  always_ff @(posedge clk) begin
    if (reset) begin
      value_q  <= aperture_cfg_pkg::IDENT_RESET; // RL9 RL10
      locked_q <= 1'b0;
    end else begin
      value_q  <= value_d; // RL9 RL10
      if (take_write) begin
        locked_q <= 1'b1; // RL13
      end
    end
  end

  assign value  = value_q;
  assign locked = locked_q;

endmodule

// ### aperture_base_config_regs.sv
`timescale 1ns/1ps

// Overview of operation
// RL1 - base resets to 00000008h in AGP mode, 00000000h in graphics mode
// RL2 - base bits 31:26 are read/write and place the aperture
// RL3 - base bit 25 reads zero unless size-select bit 3 is one
// RL4 - size bit zero after reset gives 64 MB; one allows 32 MB
// RL5 - base bits 24:4 read zero and ignore writes
// RL6 - base bit 3 reads one: aperture is prefetchable
// RL7 - base bits 2:1 read 00: place anywhere in 32-bit space
// RL8 - base bit 0 reads zero: aperture is memory space
// RL9 - subsystem vendor id resets to zero, takes one write, then read-only
// RL10 - subsystem id resets to zero, takes one write, then read-only
// RL11 - capability list pointer is read-only and returns 88h
// RL12 - aperture accesses are blocked while control bit 1 is clear
// RL13 - writing either byte of an id locks the whole id until reset
module aperture_base_config_regs (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        agp_mode_strap,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  input  wire logic [7:0]  aperture_size_select,
  input  wire logic [7:0]  aperture_control,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             aperture_hit,
  output logic             aperture_blocked
);

  localparam int HI_W = aperture_cfg_pkg::BASE_HI_WIDTH;
  localparam int ZW   = aperture_cfg_pkg::BASE_ZERO_WIDTH;
  localparam int IW   = aperture_cfg_pkg::IDENT_WIDTH;

  logic              agp_q;
  logic [HI_W-1:0]   base_hi_q;
  logic              base_b25_q;
  logic [31:0]       rdata_q;
  logic              rvalid_q;
  logic [1:0][IW-1:0] ident_val;
  logic [1:0]        ident_lock;

  // dword decode of the configuration access
  logic [5:0]  dword;
  logic        base_dw;
  logic        ident_dw;
  logic        cap_dw;
  logic        size32;
  logic        base_hi_wr;
  logic [31:0] base_fixed;
  logic [31:0] base_word;
  logic [31:0] rd_word;
  logic        ap_enable;
  logic        in_range;

  assign dword    = cfg_addr[7:2];
  assign base_dw  = dword == aperture_cfg_pkg::APERTURE_BASE_OFS[7:2];
  assign ident_dw = dword == aperture_cfg_pkg::SUBSYS_VENDOR_OFS[7:2];
  assign cap_dw   = dword == aperture_cfg_pkg::CAP_LIST_PTR_OFS[7:2];
  assign size32   = aperture_size_select[aperture_cfg_pkg::SIZE_SELECT_BIT]; // RL4

  // only the top byte lane holds writable base bits; graphics mode has no aperture
  assign base_hi_wr = cfg_wr && base_dw && cfg_be[aperture_cfg_pkg::BASE_HI_LANE] && agp_q; // RL2

  // the strap is sampled while reset is held, so the mode settles with the reset value
  always_ff @(posedge clk) begin
    if (reset) begin
      agp_q <= agp_mode_strap; // RL1
    end
  end

  // upper programmable base bits
  always_ff @(posedge clk) begin
    if (reset) begin
      base_hi_q <= aperture_cfg_pkg::BASE_RESET_AGP[aperture_cfg_pkg::BASE_HI_MSB -: HI_W]; // RL1
    end else if (base_hi_wr) begin
      base_hi_q <= cfg_wdata[aperture_cfg_pkg::BASE_HI_MSB -: HI_W]; // RL2
    end
  end

  // bit 25 is dropped when the size goes back to 64 MB, so no stale value reappears
  always_ff @(posedge clk) begin
    if (reset || !size32) begin
      base_b25_q <= 1'b0; // RL3
    end else if (base_hi_wr) begin
      base_b25_q <= cfg_wdata[aperture_cfg_pkg::BASE_SIZE_BIT]; // RL3
    end
  end

  // read-only low bits come from the mode's reset value: prefetchable, 32-bit, memory in AGP mode, all zero in graphics mode
  assign base_fixed = agp_q ? aperture_cfg_pkg::BASE_RESET_AGP
                            : aperture_cfg_pkg::BASE_RESET_GRAPH; // RL6 RL7 RL8
  assign base_word  = {base_hi_q, base_b25_q && size32, {ZW{1'b0}},
                       base_fixed[3:0]}; // RL3 RL5

  // both identifiers share one dword: vendor in the low half, subsystem in the high half
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_ident
    logic [1:0] lane_be;
    assign lane_be = (cfg_wr && ident_dw) ? cfg_be[2*gi +: 2] : 2'b00;
    write_once_reg u_ident (
      .clk    (clk),
      .reset  (reset),
      .wr_be  (lane_be),
      .wdata  (cfg_wdata[IW*gi +: IW]),
      .value  (ident_val[gi]),
      .locked (ident_lock[gi])
    ); // RL9 RL10
  end

  // read selection; unmapped dwords read as zero
  assign rd_word = base_dw  ? base_word :
                   ident_dw ? {ident_val[1], ident_val[0]} :
                   cap_dw   ? {24'h000000, aperture_cfg_pkg::CAP_LIST_PTR_VALUE} : // RL11
                              32'h00000000;

  // read data is registered and returned one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_rd;
      if (cfg_rd) begin
        rdata_q <= rd_word;
      end
    end
  end

  assign cfg_rdata  = rdata_q;
  assign cfg_rvalid = rvalid_q;

  // aperture decode: 64 MB compares bits 31:26, 32 MB also compares bit 25
  assign in_range  = (mem_addr[aperture_cfg_pkg::BASE_HI_MSB -: HI_W] == base_hi_q) &&
                     (!size32 || mem_addr[aperture_cfg_pkg::BASE_SIZE_BIT] == base_b25_q);
  assign ap_enable = aperture_control[aperture_cfg_pkg::APERTURE_EN_BIT] && agp_q;
  // combinational so a request is steered in its own cycle; tables may not exist yet
  assign aperture_hit     = mem_req && in_range && ap_enable;  // RL12
  assign aperture_blocked = mem_req && in_range && !ap_enable; // RL12

  // checks
  property p_reset_value;
    @(posedge clk) reset ##1 !reset |->
      base_word == ($past(agp_mode_strap, 2) ? aperture_cfg_pkg::BASE_RESET_AGP
                                             : aperture_cfg_pkg::BASE_RESET_GRAPH);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("base reset value wrong"); // RL1

  property p_hi_write;
    @(posedge clk) disable iff (reset) base_hi_wr |=>
      base_word[31:26] == $past(cfg_wdata[31:26]);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("upper base bits not written"); // RL2

  property p_b25_zero;
    @(posedge clk) disable iff (reset) cfg_rd && base_dw && !size32 |=>
      !cfg_rdata[aperture_cfg_pkg::BASE_SIZE_BIT];
  endproperty
  a_b25_zero: assert property (p_b25_zero) else $error("bit 25 not zero at 64 MB"); // RL3

  // the stored bit, not only the read mask, must drop at 64 MB
  property p_b25_clear;
    @(posedge clk) disable iff (reset) !size32 |=> !base_b25_q;
  endproperty
  a_b25_clear: assert property (p_b25_clear) else $error("stored bit 25 kept at 64 MB"); // RL3

  property p_b25_write;
    @(posedge clk) disable iff (reset) base_hi_wr && size32 ##1 size32 |->
      base_word[25] == $past(cfg_wdata[25]);
  endproperty
  a_b25_write: assert property (p_b25_write) else $error("bit 25 not writable at 32 MB"); // RL3 RL4

  property p_zero_field;
    @(posedge clk) disable iff (reset) base_word[24:4] == 21'h000000;
  endproperty
  a_zero_field: assert property (p_zero_field) else $error("bits 24:4 not zero"); // RL5

  property p_low_bits;
    @(posedge clk) disable iff (reset) agp_q |-> base_word[3:0] == 4'h8;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("base low bits wrong"); // RL6 RL7 RL8

  property p_vendor_hold;
    @(posedge clk) disable iff (reset) ident_lock[0] |=> $stable(ident_val[0]);
  endproperty
  a_vendor_hold: assert property (p_vendor_hold) else $error("vendor id changed"); // RL9

  property p_subsys_hold;
    @(posedge clk) disable iff (reset) ident_lock[1] |=> $stable(ident_val[1]);
  endproperty
  a_subsys_hold: assert property (p_subsys_hold) else $error("subsystem id changed"); // RL10

  property p_lock_any_byte;
    @(posedge clk) disable iff (reset) cfg_wr && ident_dw && (|cfg_be[3:2]) |=>
      ident_lock[1] ##1 ident_lock[1];
  endproperty
  a_lock_any_byte: assert property (p_lock_any_byte) else $error("id not locked"); // RL13

  property p_cap_read;
    @(posedge clk) disable iff (reset) cfg_rd && cap_dw |=>
      cfg_rvalid && cfg_rdata == 32'h00000088;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability pointer wrong"); // RL11

  property p_blocked;
    @(posedge clk) disable iff (reset)
      !aperture_control[aperture_cfg_pkg::APERTURE_EN_BIT] |->
      !aperture_hit && (mem_req && in_range) == aperture_blocked;
  endproperty
  a_blocked: assert property (p_blocked) else $error("aperture not blocked"); // RL12

  // identifier checks: reset value, first write taken, low lanes lock too
  property p_ident_reset;
    @(posedge clk) reset ##1 !reset |->
      ident_val[0] == aperture_cfg_pkg::IDENT_RESET &&
      ident_val[1] == aperture_cfg_pkg::IDENT_RESET && !(|ident_lock);
  endproperty
  a_ident_reset: assert property (p_ident_reset) else $error("id not cleared"); // RL9 RL10

  property p_vendor_write;
    @(posedge clk) disable iff (reset)
      cfg_wr && ident_dw && (&cfg_be[1:0]) && !ident_lock[0] |=>
      ident_val[0] == $past(cfg_wdata[IW-1:0]);
  endproperty
  a_vendor_write: assert property (p_vendor_write) else $error("vendor write lost"); // RL9

  property p_subsys_write;
    @(posedge clk) disable iff (reset)
      cfg_wr && ident_dw && (&cfg_be[3:2]) && !ident_lock[1] |=>
      ident_val[1] == $past(cfg_wdata[2*IW-1:IW]);
  endproperty
  a_subsys_write: assert property (p_subsys_write) else $error("subsys write lost"); // RL10

  // a write to the low lanes alone must lock the vendor id too
  property p_vendor_lock;
    @(posedge clk) disable iff (reset) cfg_wr && ident_dw && (|cfg_be[1:0]) |=>
      ident_lock[0];
  endproperty
  a_vendor_lock: assert property (p_vendor_lock) else $error("vendor id not locked"); // RL13

  // aperture base checks beyond the field masks
  property p_graphics_base;
    @(posedge clk) disable iff (reset)
      !agp_q |-> base_word == aperture_cfg_pkg::BASE_RESET_GRAPH;
  endproperty
  a_graphics_base: assert property (p_graphics_base) else $error("graphics base set"); // RL1

  // upper bits only move on a lane 3 write in AGP mode
  property p_hi_hold;
    @(posedge clk) disable iff (reset) !base_hi_wr |=> $stable(base_hi_q);
  endproperty
  a_hi_hold: assert property (p_hi_hold) else $error("upper base bits moved"); // RL2

  property p_base_read;
    @(posedge clk) disable iff (reset) cfg_rd && base_dw |=>
      cfg_rvalid && cfg_rdata == $past(base_word);
  endproperty
  a_base_read: assert property (p_base_read) else $error("base read data wrong"); // RL2

  // aperture decode checks against the readable base
  property p_hit_enabled;
    @(posedge clk) disable iff (reset)
      mem_req && in_range && ap_enable |-> aperture_hit && !aperture_blocked;
  endproperty
  a_hit_enabled: assert property (p_hit_enabled) else $error("aperture not hit"); // RL12

  property p_hit_range;
    @(posedge clk) disable iff (reset) aperture_hit |->
      (mem_addr[31:25] == base_word[31:25] || !size32) &&
      mem_addr[31:26] == base_word[31:26];
  endproperty
  a_hit_range: assert property (p_hit_range) else $error("hit outside aperture"); // RL4

  // scenarios the bench should reach
  property p_cov_hit;
    @(posedge clk) disable iff (reset) aperture_hit;
  endproperty
  c_cov_hit: cover property (p_cov_hit);

  property p_cov_lock;
    @(posedge clk) disable iff (reset) $rose(ident_lock[0]);
  endproperty
  c_cov_lock: cover property (p_cov_lock);

  property p_cov_b25;
    @(posedge clk) disable iff (reset) base_word[25];
  endproperty
  c_cov_b25: cover property (p_cov_b25);

  property p_cov_blocked;
    @(posedge clk) disable iff (reset) aperture_blocked;
  endproperty
  c_cov_blocked: cover property (p_cov_blocked);

  property p_cov_subsys_lock;
    @(posedge clk) disable iff (reset) $rose(ident_lock[1]);
  endproperty
  c_cov_subsys_lock: cover property (p_cov_subsys_lock);

endmodule

// ### aperture_base_config_regs_tb_top.sv
`timescale 1ns/1ps

module aperture_base_config_regs_tb_top;
  logic        clk;
  logic        reset;
  logic        agp_mode_strap;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid;
  logic [7:0]  aperture_size_select;
  logic [7:0]  aperture_control;
  logic        mem_req;
  logic [31:0] mem_addr;
  logic        aperture_hit;
  logic        aperture_blocked;
  int          err_total;
  int          checks;
  int          cycles = 0;

  aperture_base_config_regs i_dut (
    .clk(clk), .reset(reset), .agp_mode_strap(agp_mode_strap),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .aperture_size_select(aperture_size_select), .aperture_control(aperture_control),
    .mem_req(mem_req), .mem_addr(mem_addr), .aperture_hit(aperture_hit),
    .aperture_blocked(aperture_blocked)
  );

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // the whole run is under a hundred cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // strap is held for the whole reset so the last edge catches it
  task automatic do_reset(input logic strap);
    @(negedge clk);
    agp_mode_strap = strap;
    reset = 1'b1;
    repeat (16) @(negedge clk);
    reset = 1'b0;
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask

  // read data and its valid pulse are registered at the taking edge and checked at the next falling edge
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge clk);
    cfg_rd = 1'b0;
    chk1(cfg_rvalid, 1'b1);
    chk32(cfg_rdata, exp);
  endtask

  // decode outputs are combinational, so look shortly after the inputs move
  task automatic probe(input logic [31:0] a, input logic [7:0] ctl, input logic hit,
                       input logic blk);
    @(negedge clk);
    mem_req = 1'b1;
    mem_addr = a;
    aperture_control = ctl;
    #1;
    chk1(aperture_hit, hit);
    chk1(aperture_blocked, blk);
    @(negedge clk);
    mem_req = 1'b0;
  endtask

  initial begin
    err_total = 0;
    checks = 0;
    reset = 1'b1;
    agp_mode_strap = 1'b1;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 32'h00000000;
    aperture_size_select = 8'h00;
    aperture_control = 8'h00;
    mem_req = 1'b0;
    mem_addr = 32'h00000000;
    do_reset(1'b1);
    cfg_read(aperture_cfg_pkg::APERTURE_BASE_OFS, 32'h00000008);
    cfg_read(aperture_cfg_pkg::CAP_LIST_PTR_OFS, 32'h00000088);
    cfg_read(aperture_cfg_pkg::SUBSYS_VENDOR_OFS, 32'h00000000);
    // 64 MB: only bits 31:26 take a write, low bits stay fixed
    cfg_write(aperture_cfg_pkg::APERTURE_BASE_OFS, 4'hF, 32'hFFFFFFFF);
    cfg_read(aperture_cfg_pkg::APERTURE_BASE_OFS, 32'hFC000008);
    aperture_size_select = 8'h08;
    cfg_write(aperture_cfg_pkg::APERTURE_BASE_OFS, 4'hF, 32'hFFFFFFFF);
    cfg_read(aperture_cfg_pkg::APERTURE_BASE_OFS, 32'hFE000008);
    probe(32'hFE000100, 8'h00, 1'b0, 1'b1);
    probe(32'hFE000100, 8'h02, 1'b1, 1'b0);
    probe(32'hFC000100, 8'h02, 1'b0, 1'b0);
    aperture_size_select = 8'h00;
    probe(32'hFC000100, 8'h02, 1'b1, 1'b0);
    cfg_read(aperture_cfg_pkg::APERTURE_BASE_OFS, 32'hFC000008);
    cfg_write(aperture_cfg_pkg::APERTURE_BASE_OFS, 4'hF, 32'h00FFFFF7);
    cfg_read(aperture_cfg_pkg::APERTURE_BASE_OFS, 32'h00000008);
    cfg_write(aperture_cfg_pkg::CAP_LIST_PTR_OFS, 4'hF, 32'hFFFFFFFF);
    cfg_read(aperture_cfg_pkg::CAP_LIST_PTR_OFS, 32'h00000088);
    cfg_read(8'h40, 32'h00000000);
    // one byte of the vendor id locks all of it; the other id stays open
    cfg_write(aperture_cfg_pkg::SUBSYS_VENDOR_OFS, 4'h1, 32'h12345678);
    cfg_write(aperture_cfg_pkg::SUBSYS_VENDOR_OFS, 4'hF, 32'hAABBCCDD);
    cfg_read(aperture_cfg_pkg::SUBSYS_VENDOR_OFS, 32'hAABB0078);
    cfg_write(aperture_cfg_pkg::SUBSYS_IDENT_OFS, 4'hF, 32'h55555555);
    cfg_read(aperture_cfg_pkg::SUBSYS_VENDOR_OFS, 32'hAABB0078);
    // second reset in graphics mode clears and unlocks both ids
    do_reset(1'b0);
    cfg_read(aperture_cfg_pkg::APERTURE_BASE_OFS, 32'h00000000);
    cfg_read(aperture_cfg_pkg::SUBSYS_VENDOR_OFS, 32'h00000000);
    cfg_write(aperture_cfg_pkg::SUBSYS_VENDOR_OFS, 4'hF, 32'h9ABC4321);
    cfg_read(aperture_cfg_pkg::SUBSYS_VENDOR_OFS, 32'h9ABC4321);
    cfg_write(aperture_cfg_pkg::APERTURE_BASE_OFS, 4'hF, 32'hFFFFFFFF);
    cfg_read(aperture_cfg_pkg::APERTURE_BASE_OFS, 32'h00000000);
    probe(32'h00000100, 8'h02, 1'b0, 1'b1);
    stop_test();
  end
endmodule
